/* File: core/sbr_pkg.sv */
// shared constants and carrier types for the station bus support and ring node
package sbr_pkg;
  localparam int SYNC_W = 33;
  // pin idle levels: strobe, transmit and serial line rest high
  localparam logic [32:0] SYNC_IDLE = 33'h000002003;
  localparam int SLOT_COUNT = 16;
  localparam int NIBBLE_W = 4;
  localparam int RING_BITS = 40;
  localparam int OWN_RING_BASE = 32;
  localparam int OWN_RING_W = 8;
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [15:0] PROG_BASE = 16'h8000;
  localparam logic [15:0] PROG_LAST = 16'hFFFF;
  localparam logic [15:0] SCRATCH_BASE = 16'h2000;
  localparam logic [15:0] SCRATCH_LAST = 16'h3FFF;
  localparam logic [15:0] WIN_BASE = 16'h1000;
  localparam logic [15:0] WIN_LAST = 16'h10FF;
  localparam logic [7:0] OFS_SLOT_TX = 8'h00;
  localparam logic [7:0] OFS_SLOT_HEAD = 8'h10;
  localparam logic [7:0] OFS_SLOT_STATUS = 8'h11;
  localparam logic [7:0] OFS_RING = 8'h20;
  localparam logic [7:0] OFS_RING_LOCAL = 8'h28;
  localparam logic [7:0] OFS_OWN_LO = 8'h30;
  localparam logic [7:0] OFS_OWN_HI = 8'h31;
  localparam logic [15:0] OWN_MASK_RESET = 16'h0000;
  localparam logic [7:0] RING_LOCAL_RESET = 8'hFF;
  localparam logic [5:0] RING_LAST_IDX = 6'h27;

  typedef enum logic [0:0] {
    RING_HUNT   = 1'b0,
    RING_LOCKED = 1'b1
  } sbr_ring_state_e;

  typedef struct packed {
    logic [3:0] slot;
    logic [3:0] nibble;
  } sbr_slot_rec_s;

  typedef struct packed {
    logic       busPhase;
    logic       readNotWrite;
    logic       addressLatchStrobe;
    logic [7:0] addrData;
    logic [7:0] addrHigh;
  } sbr_cpu_in_s;
endpackage

/* File: core/sbr_node.sv */
// processor bus support, nibble bus slave, ring node and slot record fifo
`timescale 1ns/1ps
// How it works
// - low byte is latched as address while the latch strobe is high
// - whole 16-bit space decoded; program and scratch selects are outputs, the window select stays internal
// - memory output enable low whenever bus phase and direction are high
// - program store select low exactly inside the program region
// - scratch write strobe low while bus phase high and direction low
// - nibble bus has 16 four-bit slots visited in order
// - master drives strobe and slot address; this board never does
// - active-low service request raised for slot data awaiting software
// - ring packet is 40 bits: 16 master, 16 tone board, 8 ours
// - every ring bit is readable by software
// - ring order: master, tone board, this board, back to master
// - serial line idles high; transmit and receive wire-ORed onto it

module sbr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wrPtr_q, rdPtr_q;
  wire          push = inValid && inReady, pop = outValid && outReady;

  assign inReady = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData = mem_q[rdPtr_q[AW-1:0]];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (push) mem_q[wrPtr_q[AW-1:0]] <= inData;
  end
endmodule

module sbr_node (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire sbr_pkg::sbr_cpu_in_s cpuIn,
  output logic [7:0]               adOut,
  output logic                     adOe,
  output logic [7:0]               lowAddress,
  output logic                     progStoreCs_n,
  output logic                     scratchCs_n,
  output logic                     memOutputEnable_n,
  output logic                     scratchWrite_n,
  input  wire logic                nibbleStrobe_n,
  input  wire logic [3:0]          slotAddressLines,
  input  wire logic [3:0]          slotDataIn,
  output logic [3:0]               slotDataOut,
  output logic                     slotDataOe,
  output logic                     slotServiceRequest_n,
  input  wire logic                ringBitClock,
  input  wire logic                ringFrameMarker,
  input  wire logic                ringInput,
  output logic                     ringOutput,
  input  wire logic                serialTx,
  output logic                     serialRx,
  input  wire logic                serialLineIn,
  output logic                     serialLineOut,
  output logic                     serialLineOe
);
  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  // every pin input passes two flops; the first stage feeds only the second
  logic [sbr_pkg::SYNC_W-1:0] syncA_q, syncB_q;
  wire  [sbr_pkg::SYNC_W-1:0] rawIn = {cpuIn, nibbleStrobe_n, slotAddressLines, slotDataIn,
                                       ringBitClock, ringFrameMarker, ringInput,
                                       serialTx, serialLineIn};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= sbr_pkg::SYNC_IDLE;
      syncB_q <= sbr_pkg::SYNC_IDLE;
    end else begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
    end
  end

  sbr_pkg::sbr_cpu_in_s cpuS;
  wire       strS = syncB_q[13];
  wire [3:0] saS = syncB_q[12:9];
  wire [3:0] sdS = syncB_q[8:5];
  wire       rcS = syncB_q[4], rfS = syncB_q[3], riS = syncB_q[2];
  wire       txS = syncB_q[1], slS = syncB_q[0];
  assign cpuS = syncB_q[32:14];

  // processor bus: address demux and decode
  logic [7:0]  lowAddr_q;
  logic        eDly_q, rwDly_q;
  logic [7:0]  adDly_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lowAddr_q <= 8'h00;
      eDly_q    <= 1'b0;
      rwDly_q   <= 1'b1;
      adDly_q   <= 8'h00;
    end else begin
      if (cpuS.addressLatchStrobe) lowAddr_q <= cpuS.addrData;
      eDly_q  <= cpuS.busPhase;
      rwDly_q <= cpuS.readNotWrite;
      adDly_q <= cpuS.addrData;
    end
  end

  wire [15:0] fullAddr = {cpuS.addrHigh, lowAddr_q};
  wire        progHit = inRange(fullAddr, sbr_pkg::PROG_BASE, sbr_pkg::PROG_LAST);
  wire        scratchHit = inRange(fullAddr, sbr_pkg::SCRATCH_BASE, sbr_pkg::SCRATCH_LAST);
  wire        winHit = inRange(fullAddr, sbr_pkg::WIN_BASE, sbr_pkg::WIN_LAST);
  wire        readCycle = cpuS.busPhase && cpuS.readNotWrite;
  wire        writeCycle = cpuS.busPhase && !cpuS.readNotWrite;
  // direction and address are taken just after the phase falls, matching sync delay
  wire        eFall = eDly_q && !cpuS.busPhase;
  wire        winWrite = eFall && !rwDly_q && winHit;
  wire        headPop = eFall && rwDly_q && winHit && lowAddr_q == sbr_pkg::OFS_SLOT_HEAD;
  wire        statusRead = eFall && rwDly_q && winHit && lowAddr_q == sbr_pkg::OFS_SLOT_STATUS;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      progStoreCs_n     <= 1'b1;
      scratchCs_n       <= 1'b1;
      memOutputEnable_n <= 1'b1;
      scratchWrite_n    <= 1'b1;
    end else begin
      progStoreCs_n     <= !progHit;
      scratchCs_n       <= !scratchHit;
      memOutputEnable_n <= !readCycle;
      scratchWrite_n    <= !writeCycle;
    end
  end
  assign lowAddress = lowAddr_q;

  // nibble bus slave
  logic [3:0]              txSlot_q [sbr_pkg::SLOT_COUNT];
  logic [15:0]             ownMask_q;
  logic                    strDly_q, overflow_q, sreq_q, slotOe_q;
  sbr_pkg::sbr_slot_rec_s  slotLatch_q;
  logic [3:0]              slotOut_q;
  wire                     strRise = strS && !strDly_q;
  wire                     pushReq = strRise && !ownMask_q[slotLatch_q.slot];
  wire                     fifoInReady, fifoOutValid;
  sbr_pkg::sbr_slot_rec_s  fifoHead;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strDly_q    <= 1'b1;
      slotLatch_q <= '0;
      slotOut_q   <= 4'h0;
      slotOe_q    <= 1'b0;
      sreq_q      <= 1'b1;
      overflow_q  <= 1'b0;
    end else begin
      strDly_q <= strS;
      if (!strS) slotLatch_q <= '{slot: saS, nibble: sdS};
      // strobe and slot address are only ever read here, never driven
      slotOe_q  <= !strS && ownMask_q[saS];
      slotOut_q <= txSlot_q[saS];
      sreq_q    <= !fifoOutValid;
      // a slot lost to a full fifo marks overflow; set beats the read clear
      if (pushReq && !fifoInReady) overflow_q <= 1'b1;
      else if (statusRead) overflow_q <= 1'b0;
    end
  end
  assign slotDataOut = slotOut_q;
  assign slotDataOe = slotOe_q;
  assign slotServiceRequest_n = sreq_q;

  sbr_fifo #(
    .W     (sbr_pkg::FIFO_W),
    .DEPTH (sbr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .rst_n    (rst_n),
    .inValid  (pushReq),
    .inReady  (fifoInReady),
    .inData   (slotLatch_q),
    .outValid (fifoOutValid),
    .outReady (headPop),
    .outData  (fifoHead)
  );

  // ring node
  sbr_pkg::sbr_ring_state_e  ringState_q;
  logic [5:0]                ringIdx_q;
  logic [sbr_pkg::RING_BITS-1:0] ringBits_q;
  logic [7:0]                ringLocal_q;
  logic                      rcDly_q, ringOut_q;
  wire                       rcRise = rcS && !rcDly_q;
  wire [5:0]                 bitIdxNow = rfS ? 6'h00 : ringIdx_q;
  wire                       ringLocked = rfS || ringState_q == sbr_pkg::RING_LOCKED;
  wire                       ownPos = ringLocked && bitIdxNow >= 6'(sbr_pkg::OWN_RING_BASE)
                             && bitIdxNow < 6'(sbr_pkg::OWN_RING_BASE + sbr_pkg::OWN_RING_W);
  wire [2:0]                 ownBit = 3'(bitIdxNow - 6'(sbr_pkg::OWN_RING_BASE));

  // each bit leaves within three clocks of the ring-clock rise that samples it; node realigns on marker
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ringState_q <= sbr_pkg::RING_HUNT;
      ringIdx_q   <= 6'h00;
      ringBits_q  <= '0;
      rcDly_q     <= 1'b0;
      ringOut_q   <= 1'b1;
    end else begin
      rcDly_q <= rcS;
      if (rcRise) begin
        ringOut_q <= ownPos ? ringLocal_q[ownBit] : riS;
        if (ringLocked) ringBits_q[bitIdxNow] <= riS;
        if (rfS) begin
          ringState_q <= sbr_pkg::RING_LOCKED;
          ringIdx_q   <= 6'h01;
        end else if (ringIdx_q == sbr_pkg::RING_LAST_IDX) begin
          // last packet bit reached without a marker: hunt, inserting nothing until the marker returns
          ringState_q <= sbr_pkg::RING_HUNT;
          ringIdx_q   <= 6'h00;
        end else begin
          ringIdx_q <= ringIdx_q + 6'h01;
        end
      end
    end
  end
  assign ringOutput = ringOut_q;

  // processor writes into the window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ownMask_q   <= sbr_pkg::OWN_MASK_RESET;
      ringLocal_q <= sbr_pkg::RING_LOCAL_RESET;
      for (int i = 0; i < sbr_pkg::SLOT_COUNT; i++) txSlot_q[i] <= 4'h0;
    end else if (winWrite) begin
      if (lowAddr_q[7:4] == sbr_pkg::OFS_SLOT_TX[7:4]) txSlot_q[lowAddr_q[3:0]] <= adDly_q[3:0];
      else if (lowAddr_q == sbr_pkg::OFS_RING_LOCAL) ringLocal_q <= adDly_q;
      else if (lowAddr_q == sbr_pkg::OFS_OWN_LO) ownMask_q[7:0] <= adDly_q;
      else if (lowAddr_q == sbr_pkg::OFS_OWN_HI) ownMask_q[15:8] <= adDly_q;
    end
  end

  // read data; unmapped window offsets read as zero
  wire [2:0] ringByte = 3'(lowAddr_q - sbr_pkg::OFS_RING);
  wire       isRing = lowAddr_q >= sbr_pkg::OFS_RING && lowAddr_q < sbr_pkg::OFS_RING + 8'h05;
  wire [7:0] rdMux =
    (lowAddr_q[7:4] == sbr_pkg::OFS_SLOT_TX[7:4]) ? {4'h0, txSlot_q[lowAddr_q[3:0]]} :
    (lowAddr_q == sbr_pkg::OFS_SLOT_HEAD) ? (fifoOutValid ? fifoHead : 8'h00) :
    (lowAddr_q == sbr_pkg::OFS_SLOT_STATUS) ? {6'h00, overflow_q, fifoOutValid} :
    isRing ? ringBits_q[ringByte*8 +: 8] :
    (lowAddr_q == sbr_pkg::OFS_RING_LOCAL) ? ringLocal_q :
    (lowAddr_q == sbr_pkg::OFS_OWN_LO) ? ownMask_q[7:0] :
    (lowAddr_q == sbr_pkg::OFS_OWN_HI) ? ownMask_q[15:8] : 8'h00;

  logic [7:0] adOut_q;
  logic       adOe_q, lineOe_q, serialRx_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      adOut_q    <= 8'h00;
      adOe_q     <= 1'b0;
      lineOe_q   <= 1'b0;
      serialRx_q <= 1'b1;
    end else begin
      adOut_q    <= rdMux;
      adOe_q     <= readCycle && winHit && !cpuS.addressLatchStrobe;
      lineOe_q   <= !txS;
      serialRx_q <= slS;
    end
  end
  assign adOut = adOut_q;
  assign adOe = adOe_q;
  assign serialLineOut = 1'b0;
  assign serialLineOe = lineOe_q;
  assign serialRx = serialRx_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_addrLatch;
    cpuS.addressLatchStrobe |=> lowAddress == $past(cpuS.addrData); endproperty
  a_addrLatch: assert property (p_addrLatch) else $error("low address not latched");
  property p_decodeExclusive;
    !(winHit && progHit) && !(scratchHit && progHit) && !(winHit && scratchHit); endproperty
  a_decodeExclusive: assert property (p_decodeExclusive) else $error("decode overlap");
  property p_memOe;
    readCycle |=> !memOutputEnable_n ##1 (memOutputEnable_n == !$past(readCycle)); endproperty
  a_memOe: assert property (p_memOe) else $error("output enable wrong");
  property p_progCs;
    ##1 progStoreCs_n == !$past(progHit) && scratchCs_n == !$past(scratchHit); endproperty
  a_progCs: assert property (p_progCs) else $error("program select wrong");
  property p_scratchWe;
    writeCycle |=> !scratchWrite_n && memOutputEnable_n; endproperty
  a_scratchWe: assert property (p_scratchWe) else $error("scratch write wrong");
  property p_serviceReq;
    fifoOutValid && !headPop |=> !slotServiceRequest_n ##1 (fifoOutValid || $past(headPop));
  endproperty
  a_serviceReq: assert property (p_serviceReq) else $error("request missing");
  property p_slotHold;
    fifoOutValid && !headPop |=> fifoOutValid && $stable(fifoHead); endproperty
  a_slotHold: assert property (p_slotHold) else $error("slot data lost");
  property p_slotDrive;
    slotDataOe |-> $past(!strS) && ownMask_q[$past(saS)]; endproperty
  a_slotDrive: assert property (p_slotDrive) else $error("drove foreign slot");
  property p_ringAlign;
    rcRise && rfS |=> ringIdx_q == 6'h01 && ringState_q == sbr_pkg::RING_LOCKED; endproperty
  a_ringAlign: assert property (p_ringAlign) else $error("ring not aligned");
  property p_ringForward;
    rcRise && !ownPos |=> ringOutput == $past(riS); endproperty
  a_ringForward: assert property (p_ringForward) else $error("bit not forwarded");
  property p_ringRead;
    rcRise && ringLocked |=> ringBits_q[$past(bitIdxNow)] == $past(riS); endproperty
  a_ringRead: assert property (p_ringRead) else $error("ring bit not stored");
  property p_serialLine;
    serialLineOe |-> $past(!txS) && serialLineOut == 1'b0; endproperty
  a_serialLine: assert property (p_serialLine) else $error("serial drive wrong");
endmodule

/* File: verif/sbr_far_model.sv */
// control master and tone board stand-in: nibble bus master and ring source
`timescale 1ns/1ps
module sbr_far_model (
  input  wire logic        clock,
  input  wire logic [39:0] ringPattern,
  input  wire logic        slotGo,
  input  wire logic [4:0]  slotsToSend,
  output logic             slotBusy,
  output logic             nibbleStrobe_n,
  output logic [3:0]       slotAddressLines,
  output logic [3:0]       slotDataIn,
  output logic             ringBitClock,
  output logic             ringFrameMarker,
  output logic             ringInput,
  output logic [5:0]       ringIdx
);
  initial begin
    slotBusy = 1'b0;
    nibbleStrobe_n = 1'b1;
    slotAddressLines = 4'h0;
    slotDataIn = 4'h0;
  end

  // strobe period shortened from the divide-by-640 to keep runs short
  always @(posedge slotGo) begin
    slotBusy = 1'b1;
    for (int i = 0; i < slotsToSend; i++) begin
      @(negedge clock);
      slotAddressLines = 4'(i);
      slotDataIn = 4'(i) ^ 4'hA;
      nibbleStrobe_n = 1'b0;
      repeat (4) @(negedge clock);
      nibbleStrobe_n = 1'b1;
      repeat (12) @(negedge clock);
    end
    // released lines do not keep their last value
    slotDataIn = ~slotDataIn;
    slotBusy = 1'b0;
  end

  // ring runs free: the packet circulates continually
  initial begin
    ringBitClock = 1'b0;
    ringIdx = 6'h00;
    ringFrameMarker = 1'b1;
    ringInput = 1'b0;
    #3;
    ringInput = ringPattern[0];
    forever begin
      #40 ringBitClock = 1'b1;
      #40 ringBitClock = 1'b0;
      ringIdx = (ringIdx == 6'd39) ? 6'h00 : ringIdx + 6'h01;
      ringFrameMarker = (ringIdx == 6'h00);
      ringInput = ringPattern[ringIdx];
    end
  end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the bus support and ring node
`timescale 1ns/1ps
module testbench;
  logic                 clock, rst_n;
  sbr_pkg::sbr_cpu_in_s cpuIn;
  logic [7:0]           adOut, lowAddress, localByte, expQ[$];
  logic                 adOe, progStoreCs_n, scratchCs_n, memOutputEnable_n, scratchWrite_n;
  logic                 nibbleStrobe_n, slotDataOe, slotServiceRequest_n, slotGo, slotBusy;
  logic [3:0]           slotAddressLines, slotDataOut, farData;
  logic                 ringBitClock, ringFrameMarker, ringInput, ringOutput, rBit;
  logic                 serialTx, serialRx, serialLineOut, serialLineOe, farSerialLow;
  logic [5:0]           ringIdx, rIdx;
  logic [39:0]          ringPattern;
  logic [4:0]           slotsToSend;
  logic [15:0]          a;
  int                   mismatches, totalChecks, oeCnt, ownSeen;
  bit                   ringCheckEn;
  wire [3:0] slotWire = slotDataOe ? slotDataOut : farData;
  // pull-up on the shared serial line; either side may pull it low
  wire serialLine = (serialLineOe ? serialLineOut : 1'b1) & ~farSerialLow;
  logic [15:0] edges [6] = '{16'h7FFF, 16'h8000, 16'h1FFF, 16'h2000, 16'h3FFF, 16'h4000};

  sbr_node u_sbr_node (.clock(clock), .rst_n(rst_n), .cpuIn(cpuIn), .adOut(adOut),
    .adOe(adOe), .lowAddress(lowAddress), .progStoreCs_n(progStoreCs_n),
    .scratchCs_n(scratchCs_n), .memOutputEnable_n(memOutputEnable_n),
    .scratchWrite_n(scratchWrite_n), .nibbleStrobe_n(nibbleStrobe_n),
    .slotAddressLines(slotAddressLines), .slotDataIn(slotWire), .slotDataOut(slotDataOut),
    .slotDataOe(slotDataOe), .slotServiceRequest_n(slotServiceRequest_n),
    .ringBitClock(ringBitClock), .ringFrameMarker(ringFrameMarker), .ringInput(ringInput),
    .ringOutput(ringOutput), .serialTx(serialTx), .serialRx(serialRx),
    .serialLineIn(serialLine), .serialLineOut(serialLineOut), .serialLineOe(serialLineOe));

  sbr_far_model u_sbr_far_model (.clock(clock), .ringPattern(ringPattern), .slotGo(slotGo),
    .slotsToSend(slotsToSend), .slotBusy(slotBusy), .nibbleStrobe_n(nibbleStrobe_n),
    .slotAddressLines(slotAddressLines), .slotDataIn(farData), .ringBitClock(ringBitClock),
    .ringFrameMarker(ringFrameMarker), .ringInput(ringInput), .ringIdx(ringIdx));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input bit ok, input string what);
    totalChecks++;
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic testDone();
    if (mismatches == 0 && totalChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cpuCycle(input logic [15:0] ad, input logic rd, input logic [7:0] wd,
                          input logic [7:0] ex, input bit isWin);
    @(negedge clock);
    cpuIn.addrHigh = ad[15:8];
    cpuIn.addrData = ad[7:0];
    cpuIn.readNotWrite = rd;
    cpuIn.addressLatchStrobe = 1'b1;
    repeat (4) @(negedge clock);
    chk(lowAddress === ad[7:0], "low address latch");
    chk(progStoreCs_n === ~(ad >= sbr_pkg::PROG_BASE), "program select");
    chk(scratchCs_n === ~(ad >= sbr_pkg::SCRATCH_BASE && ad <= sbr_pkg::SCRATCH_LAST),
        "scratch select");
    cpuIn.addressLatchStrobe = 1'b0;
    cpuIn.addrData = rd ? ~ad[7:0] : wd;
    cpuIn.busPhase = 1'b1;
    if (rd && isWin) expQ.push_back(ex);
    repeat (4) @(negedge clock);
    chk(memOutputEnable_n === ~rd && scratchWrite_n === rd, "cycle strobes");
    cpuIn.busPhase = 1'b0;
    repeat (4) @(negedge clock);
    chk(memOutputEnable_n === 1'b1 && scratchWrite_n === 1'b1, "strobes idle");
  endtask

  task automatic win(input logic [7:0] ofs, input logic rd, input logic [7:0] v);
    cpuCycle({8'h10, ofs}, rd, v, v, 1'b1);
  endtask

  task automatic runSlots(input logic [4:0] n);
    int k;
    @(negedge clock);
    slotsToSend = n;
    slotGo = 1'b1;
    @(negedge clock);
    slotGo = 1'b0;
    k = 0;
    while (slotBusy === 1'b1 && k < 2000) begin
      @(negedge clock);
      k++;
    end
    chk(k < 2000, "slot run hung");
    repeat (8) @(negedge clock);
  endtask

  // read data is taken on the second cycle of the output enable
  always @(negedge clock) begin
    oeCnt = (adOe === 1'b1) ? oeCnt + 1 : 0;
    if (oeCnt == 2) begin
      if (expQ.size() == 0) chk(1'b0, "unexpected read drive");
      else chk(adOut === expQ.pop_front(), "read data");
    end
    if (slotDataOe === 1'b1) begin
      ownSeen++;
      chk(slotAddressLines === 4'h2 && slotDataOut === 4'h5, "own slot drive");
    end
  end

  always @(posedge ringBitClock) if (ringCheckEn) begin
    rIdx = ringIdx;
    rBit = ringInput;
    #48;
    chk(ringOutput === (rIdx >= 6'd32 ? localByte[rIdx - 6'd32] : rBit), "ring bit");
  end

  initial begin
    #700000;
    mismatches++;
    testDone();
  end

  initial begin
    void'($urandom(96));
    ringPattern = {8'($urandom), 32'($urandom)};
    cpuIn = '0;
    rst_n = 1'b0;
    serialTx = 1'b1;
    farSerialLow = 1'b0;
    slotGo = 1'b0;
    slotsToSend = 5'h00;
    localByte = sbr_pkg::RING_LOCAL_RESET;
    repeat (20) @(negedge clock);
    chk(ringOutput === 1'b1 && slotServiceRequest_n === 1'b1 && adOe === 1'b0, "reset state");
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    serialTx = 1'b0;
    // own drive reaches the receive echo through two more sync stages
    repeat (8) @(negedge clock);
    chk(serialLineOe === 1'b1 && serialRx === 1'b0, "serial transmit");
    serialTx = 1'b1;
    farSerialLow = 1'b1;
    repeat (4) @(negedge clock);
    chk(serialLineOe === 1'b0 && serialRx === 1'b0, "serial receive");
    farSerialLow = 1'b0;
    foreach (edges[i]) cpuCycle(edges[i], 1'(i), 8'h5A, 8'h00, 1'b0);
    for (int i = 0; i < 8; i++) begin
      a = 16'($urandom);
      if (a[15:8] == 8'h10) a[15:8] = 8'h11;
      cpuCycle(a, 1'($urandom), 8'($urandom), 8'h00, 1'b0);
    end
    // node must be locked before local bits are replaced
    repeat (100) @(posedge ringBitClock);
    ringCheckEn = 1'b1;
    repeat (45) @(posedge ringBitClock);
    ringCheckEn = 1'b0;
    #60;
    localByte = 8'($urandom);
    win(sbr_pkg::OFS_RING_LOCAL, 1'b0, localByte);
    repeat (3) @(posedge ringBitClock);
    ringCheckEn = 1'b1;
    repeat (45) @(posedge ringBitClock);
    for (int k = 0; k < 5; k++) begin
      win(sbr_pkg::OFS_RING + 8'(k), 1'b1, ringPattern[8*k +: 8]);
    end
    runSlots(5'd17);
    chk(slotServiceRequest_n === 1'b0, "request pending");
    win(sbr_pkg::OFS_SLOT_STATUS, 1'b1, 8'h03);
    for (int i = 0; i < 16; i++) win(sbr_pkg::OFS_SLOT_HEAD, 1'b1, {4'(i), 4'(i) ^ 4'hA});
    win(sbr_pkg::OFS_SLOT_STATUS, 1'b1, 8'h00);
    chk(slotServiceRequest_n === 1'b1, "request cleared");
    win(sbr_pkg::OFS_SLOT_HEAD, 1'b1, 8'h00);
    win(8'h50, 1'b1, 8'h00);
    win(sbr_pkg::OFS_OWN_LO, 1'b0, 8'h04);
    win(sbr_pkg::OFS_SLOT_TX + 8'h02, 1'b0, 8'h05);
    ownSeen = 0;
    runSlots(5'd4);
    chk(ownSeen > 0, "own slot never driven");
    win(sbr_pkg::OFS_SLOT_HEAD, 1'b1, 8'h0A);
    win(sbr_pkg::OFS_SLOT_HEAD, 1'b1, 8'h1B);
    win(sbr_pkg::OFS_SLOT_HEAD, 1'b1, 8'h39);
    chk(expQ.size() == 0, "reads left unanswered");
    testDone();
  end
endmodule
